// ### verilog/rfp_defines.svh
`ifndef RFP_DEFINES_SVH
`define RFP_DEFINES_SVH

// Timing
`define RFP_CLK_PERIOD_NS   5
`define RFP_TICK_PERIOD_NS  1000
`define RFP_PRESCALE        (`RFP_TICK_PERIOD_NS / `RFP_CLK_PERIOD_NS)
`define RFP_OC_WAIT_MS      12
`define RFP_OC_WAIT_TICKS   (`RFP_OC_WAIT_MS * 1000000 / `RFP_TICK_PERIOD_NS)

// Sizes
`define RFP_NUM_CH          4
`define RFP_EV_W            5

// Register offsets (byte addresses)
`define RFP_ADDR_CTRL       4'h0
`define RFP_ADDR_STATUS     4'h4
`define RFP_ADDR_MASK       4'h8
`define RFP_ADDR_STATE      4'hC

// Event bit positions in status and mask
`define RFP_EV_UV           0
`define RFP_EV_OV           1
`define RFP_EV_OC           2
`define RFP_EV_LIM          3
`define RFP_EV_LATCH        4

// Reset values
`define RFP_CTRL_RST        1'h1
`define RFP_MASK_RST        5'h00

`endif

// ### verilog/rfp_pkg.sv
package rfp_pkg;

   typedef enum logic [2:0] {
      RFP_OFF,
      RFP_SOFTSTART,
      RFP_RUN,
      RFP_OC_WAIT,
      RFP_OV_CLAMP,
      RFP_LATCHED
   } rfp_state_e;

   typedef logic [3:0]  rfp_addr_t;
   typedef logic [31:0] rfp_data_t;

   typedef struct packed {
      logic upper;
      logic lower;
   } rfp_gate_s;

   typedef struct packed {
      rfp_state_e  state;
      logic        sw_en;
      logic        uv_flag;
      logic        pg_good;
      logic        ss_run;
      logic        ext_oe_n;
      logic [7:0]  pre_cnt;
      logic [13:0] wait_cnt;
      logic [3:0]  lim_prev;
      logic [4:0]  status;
      logic [4:0]  mask;
      logic        irq;
      rfp_data_t   rd_data;
   } rfp_top_s;

endpackage

// ### verilog/rfp_chan_gate.sv
`timescale 1ns/1ps
module rfp_chan_gate (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Mode from the sequencer
   input  wire logic gate_off,
   input  wire logic clamp_low,
   // Channel inputs
   input  wire logic limit,
   input  wire logic pwm,
   // Gate commands
   output logic      upper_r,
   output logic      lower_r
);
   import rfp_pkg::*;

   rfp_gate_s g_r;
   rfp_gate_s g_nxt;

   always_comb begin
      g_nxt = '0;
      if (gate_off) begin
         g_nxt = '0;
      end else if (clamp_low || limit) begin
         g_nxt.lower = 1'b1;
      end else begin
         g_nxt.upper = pwm;
         g_nxt.lower = ~pwm;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         g_r <= '0;
      end else begin
         g_r <= g_nxt;
      end
   end

   assign upper_r = g_r.upper;
   assign lower_r = g_r.lower;

endmodule // rfp_chan_gate

// ### verilog/rfp_top.sv
// How it works
// - Undervoltage means the sensed output is below 60 percent of the identification-code voltage.
// - Undervoltage only pulls power-good low; the gates keep regulating.
// - Power-good returns high only once the output rises above 70 percent of that voltage.
// - An overvoltage, such as from an open sense line, stops regulation and latches off.
// - The average-current trip flag starts overcurrent shutdown at once.
// - Shutdown drives all gates low, floats the external phase and pulls power-good low.
// - Shutdown is held with everything off for twelve milliseconds.
// - After the wait a new soft-start begins if still enabled.
// - Trip, wait and retry repeat without limit until disabled or the fault clears.
// - A channel over its limit while the gates are driven gets its upper gate low and lower gate high at once.
// - That upper gate stays low until the channel limit flag drops.
// - Latch-off is cleared only by dropping enable or by reset, then soft-start may restart.
// - Power-good is low during shutdown and soft-start and rises only after soft-start.
`timescale 1ns/1ps
`include "rfp_defines.svh"
module rfp_top #(
   parameter int OC_WAIT_TICKS = `RFP_OC_WAIT_TICKS
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 arst_n,
   // Register port
   input  wire rfp_pkg::rfp_addr_t   addr,
   input  wire rfp_pkg::rfp_data_t   wr_data,
   input  wire logic                 wr_strobe,
   input  wire logic                 rd_strobe,
   output rfp_pkg::rfp_data_t        rd_data_r,
   output logic                      irq_r,
   // Enable and soft-start handshake
   input  wire logic                 regulator_enable,
   input  wire logic                 soft_start_done,
   output logic                      soft_start_run_r,
   // Comparator flags
   input  wire logic                 uv_below_60,
   input  wire logic                 out_above_70,
   input  wire logic                 ov_trip,
   input  wire logic                 avg_overcurrent_trip,
   input  wire logic [3:0]           channel_current_limit,
   // Modulator requests
   input  wire logic [3:0]           pwm_req,
   // Gate drive
   output logic [2:0]                upper_gate_cmd,
   output logic [2:0]                lower_gate_cmd,
   output logic                      external_phase_pwm,
   output logic                      external_phase_pwm_oe_n,
   // Power-good open drain
   output logic                      power_good_out,
   output logic                      power_good_oe_n
);
   import rfp_pkg::*;

   logic [1:0] rst_sync;
   logic       rst_n;
   rfp_top_s   r;
   rfp_top_s   n;
   logic       en_eff;
   logic       tick;
   logic       gate_off;
   logic       clamp_low;
   logic [4:0] ev;
   logic [4:0] w1c;
   logic [3:0] upper_all;
   logic [3:0] lower_all;

   // Reset released through two flops
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign en_eff = regulator_enable & r.sw_en;
   assign tick   = (r.pre_cnt == 8'h00);

   always_comb begin
      n   = r;
      ev  = 5'h00;
      w1c = 5'h00;
      n.pre_cnt = tick ? 8'(`RFP_PRESCALE - 1) : r.pre_cnt - 8'h01;

      // Hysteresis on the undervoltage flag
      if (uv_below_60) begin
         n.uv_flag = 1'b1;
      end else if (out_above_70) begin
         n.uv_flag = 1'b0;
      end

      case (r.state)
         RFP_OFF: begin
            if (en_eff) begin
               n.state = RFP_SOFTSTART;
            end
         end
         RFP_SOFTSTART, RFP_RUN: begin
            if (ov_trip) begin
               n.state = RFP_OV_CLAMP;
            end else if (avg_overcurrent_trip) begin
               n.state    = RFP_OC_WAIT;
               n.wait_cnt = 14'(OC_WAIT_TICKS - 1);
               n.pre_cnt  = 8'(`RFP_PRESCALE - 1);
            end else if (r.state == RFP_SOFTSTART && soft_start_done) begin
               n.state = RFP_RUN;
            end
         end
         RFP_OC_WAIT: begin
            if (tick) begin
               if (r.wait_cnt == 14'h0000) begin
                  n.state = RFP_SOFTSTART;
               end else begin
                  n.wait_cnt = r.wait_cnt - 14'h0001;
               end
            end
         end
         RFP_OV_CLAMP: begin
            // Lower gates hold the output down until the trip clears
            if (!ov_trip) begin
               n.state = RFP_LATCHED;
            end
         end
         RFP_LATCHED: begin
            n.state = RFP_LATCHED;
         end
         default: begin
            n.state = RFP_OFF;
         end
      endcase

      // Disable overrides every state and clears the latch
      if (!en_eff) begin
         n.state = RFP_OFF;
      end

      // Power-good only in regulation and outside undervoltage
      n.pg_good  = (n.state == RFP_RUN) && !n.uv_flag;
      n.ss_run   = (n.state == RFP_SOFTSTART);
      n.ext_oe_n = (n.state == RFP_OFF) || (n.state == RFP_OC_WAIT) ||
                   (n.state == RFP_LATCHED);

      // Events
      ev[`RFP_EV_UV]    = n.uv_flag && !r.uv_flag && (r.state == RFP_RUN);
      ev[`RFP_EV_OV]    = (n.state == RFP_OV_CLAMP) && (r.state != RFP_OV_CLAMP);
      ev[`RFP_EV_OC]    = (n.state == RFP_OC_WAIT) && (r.state != RFP_OC_WAIT);
      ev[`RFP_EV_LIM]   = |(channel_current_limit & ~r.lim_prev);
      ev[`RFP_EV_LATCH] = (n.state == RFP_LATCHED) && (r.state != RFP_LATCHED);
      n.lim_prev = channel_current_limit;

      // Register writes
      if (wr_strobe) begin
         case (addr)
            `RFP_ADDR_CTRL:   n.sw_en = wr_data[0];
            `RFP_ADDR_STATUS: w1c = wr_data[4:0];
            `RFP_ADDR_MASK:   n.mask = wr_data[4:0];
            default: ;
         endcase
      end
      // A new event wins over a clear in the same cycle
      n.status = (r.status & ~w1c) | ev;
      n.irq    = |(n.status & n.mask);

      // Register reads: data valid in the cycle after the strobe only
      n.rd_data = 32'h0000_0000;
      if (rd_strobe) begin
         case (addr)
            `RFP_ADDR_CTRL:   n.rd_data = {31'h0, r.sw_en};
            `RFP_ADDR_STATUS: n.rd_data = {27'h0, r.status};
            `RFP_ADDR_MASK:   n.rd_data = {27'h0, r.mask};
            `RFP_ADDR_STATE:  n.rd_data = {22'h0, channel_current_limit, r.pg_good,
                                           r.uv_flag, en_eff, r.state};
            default:          n.rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r          <= '0;
         r.state    <= RFP_OFF;
         r.sw_en    <= `RFP_CTRL_RST;
         r.mask     <= `RFP_MASK_RST;
         r.ext_oe_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Gate mode follows the next state so the gates move on the same edge
   assign gate_off  = n.ext_oe_n;
   assign clamp_low = (n.state == RFP_OV_CLAMP);

   genvar gi;
   generate
      for (gi = 0; gi < `RFP_NUM_CH; gi++) begin : g_ch
         rfp_chan_gate u_gate (
            .sys_clk   (sys_clk),
            .rst_n     (rst_n),
            .gate_off  (gate_off),
            .clamp_low (clamp_low),
            .limit     (channel_current_limit[gi]),
            .pwm       (pwm_req[gi]),
            .upper_r   (upper_all[gi]),
            .lower_r   (lower_all[gi])
         );
      end
   endgenerate

   assign upper_gate_cmd          = upper_all[2:0];
   assign lower_gate_cmd          = lower_all[2:0];
   // External driver makes its own lower gate from a low level
   assign external_phase_pwm      = upper_all[3];
   assign external_phase_pwm_oe_n = r.ext_oe_n;
   assign power_good_out          = 1'b0;
   assign power_good_oe_n         = r.pg_good;
   assign soft_start_run_r        = r.ss_run;
   assign rd_data_r               = r.rd_data;
   assign irq_r                   = r.irq;

   // Checks
   a_uv_pg_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
      uv_below_60 |=> !power_good_oe_n)
      else $error("power good not low on undervoltage");

   a_uv_hyst_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.uv_flag && !out_above_70) |=> !power_good_oe_n)
      else $error("power good released before 70 percent");

   a_uv_keeps_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_RUN && uv_below_60 && en_eff && !ov_trip && !avg_overcurrent_trip)
      |=> (r.state == RFP_RUN))
      else $error("undervoltage left regulation");

   a_ov_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_LATCHED && en_eff) |=> (r.state == RFP_LATCHED))
      else $error("latch-off left while enabled");

   a_oc_all_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((r.state == RFP_RUN || r.state == RFP_SOFTSTART) && en_eff && !ov_trip
       && avg_overcurrent_trip)
      |=> (upper_gate_cmd == 3'h0 && lower_gate_cmd == 3'h0 && external_phase_pwm_oe_n
           && !power_good_oe_n)
      ##1 (r.state == RFP_OC_WAIT))
      else $error("overcurrent shutdown outputs wrong");

   a_oc_wait_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state != RFP_OC_WAIT) ##1 (r.state == RFP_OC_WAIT)
      |-> (r.wait_cnt == 14'(OC_WAIT_TICKS - 1)) && (r.pre_cnt == 8'(`RFP_PRESCALE - 1)))
      else $error("overcurrent wait not loaded");

   a_oc_wait_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_OC_WAIT && en_eff && !(tick && r.wait_cnt == 14'h0000))
      |=> (r.state == RFP_OC_WAIT))
      else $error("overcurrent wait ended early");

   a_oc_retry: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_OC_WAIT && en_eff && tick && r.wait_cnt == 14'h0000)
      |=> (r.state == RFP_SOFTSTART) && soft_start_run_r)
      else $error("no retry after overcurrent wait");

   a_chan_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (channel_current_limit[0] && r.state == RFP_RUN && en_eff && !ov_trip
       && !avg_overcurrent_trip) |=> (!upper_gate_cmd[0] && lower_gate_cmd[0]))
      else $error("channel limit did not override gates");

   a_pg_only_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
      power_good_oe_n |-> (r.state == RFP_RUN) && !r.uv_flag)
      else $error("power good high outside regulation");

   a_oc_rearm: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_SOFTSTART && en_eff && !ov_trip && avg_overcurrent_trip)
      |=> (r.state == RFP_OC_WAIT))
      else $error("overcurrent retry did not trip again");

   a_limit_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
      channel_current_limit[1] |=> !upper_gate_cmd[1])
      else $error("limited upper gate went high");

   a_disable_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !en_eff |=> (r.state == RFP_OFF) && external_phase_pwm_oe_n)
      else $error("disable did not turn the regulator off");

   a_tick_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick |=> (r.pre_cnt == 8'(`RFP_PRESCALE - 1)))
      else $error("prescaler not reloaded after tick");

   a_wait_gates_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_OC_WAIT) |-> (upper_gate_cmd == 3'h0) && (lower_gate_cmd == 3'h0)
      && external_phase_pwm_oe_n)
      else $error("gates driven during overcurrent wait");

   c_oc_retry: cover property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_OC_WAIT) ##1 (r.state == RFP_SOFTSTART));
   c_ov_latched: cover property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_OV_CLAMP) ##1 (r.state == RFP_LATCHED));
   c_uv_recover: cover property (@(posedge sys_clk) disable iff (!rst_n)
      r.uv_flag && r.state == RFP_RUN ##1 !r.uv_flag && power_good_oe_n);
   c_chan_limit: cover property (@(posedge sys_clk) disable iff (!rst_n)
      r.state == RFP_RUN && channel_current_limit[1] ##1 lower_gate_cmd[1]);
   c_oc_rearm: cover property (@(posedge sys_clk) disable iff (!rst_n)
      (r.state == RFP_SOFTSTART) ##1 (r.state == RFP_OC_WAIT));

endmodule // rfp_top

// ### tb/rfp_stage_model.sv
`timescale 1ns/1ps
module rfp_stage_model #(
   parameter int SS_CYCLES = 8
) (
   // Clock
   sys_clk,
   // Ramp request and stall from the bench
   soft_start_run_r,
   hold_ramp,
   // Pins driven by the regulator
   power_good_out,
   power_good_oe_n,
   external_phase_pwm,
   external_phase_pwm_oe_n,
   // Ramp finished and resolved pin levels
   soft_start_done,
   pg_line,
   ext_phase_wire
);
   input  wire logic sys_clk;
   input  wire logic soft_start_run_r;
   input  wire logic hold_ramp;
   input  wire logic power_good_out;
   input  wire logic power_good_oe_n;
   input  wire logic external_phase_pwm;
   input  wire logic external_phase_pwm_oe_n;
   output logic      soft_start_done = 1'b0;
   output logic      pg_line;
   output logic      ext_phase_wire;

   int   ramp_cnt = 0;
   logic ext_last = 1'b0;

   // A held ramp lets the bench model a slow power stage
   always @(posedge sys_clk) begin
      if (soft_start_run_r !== 1'b1 || hold_ramp) begin
         ramp_cnt <= 0;
         soft_start_done <= 1'b0;
      end else begin
         ramp_cnt <= ramp_cnt + 1;
         soft_start_done <= (ramp_cnt >= SS_CYCLES);
      end
      if (external_phase_pwm_oe_n === 1'b0) begin
         ext_last <= external_phase_pwm;
      end
   end

   // Pull-up on the open-drain good line
   assign pg_line = power_good_oe_n ? 1'b1 : power_good_out;
   // A floating phase line shows the opposite of its last driven value
   assign ext_phase_wire = external_phase_pwm_oe_n ? ~ext_last : external_phase_pwm;
endmodule // rfp_stage_model

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "rfp_defines.svh"
module testbench;
   import rfp_pkg::*;
   localparam int TICKS    = 3;
   localparam int WAIT_CYC = TICKS * 200;
   // Clock, reset and register port
   logic       sys_clk   = 1'b0;
   logic       arst_n    = 1'b0;
   rfp_addr_t  addr      = 4'h0;
   rfp_data_t  wr_data   = 32'h0;
   logic       wr_strobe = 1'b0;
   logic       rd_strobe = 1'b0;
   rfp_data_t  rd_data_r;
   logic       irq_r;
   // Control and comparator flags
   logic       regulator_enable      = 1'b0;
   logic       hold_ramp             = 1'b1;
   logic       uv_below_60           = 1'b0;
   logic       out_above_70          = 1'b0;
   logic       ov_trip               = 1'b0;
   logic       avg_overcurrent_trip  = 1'b0;
   logic [3:0] channel_current_limit = 4'h0;
   logic [3:0] pwm_req               = 4'h5;
   // Outputs and resolved pins
   logic       soft_start_done;
   logic       soft_start_run_r;
   logic [2:0] upper_gate_cmd;
   logic [2:0] lower_gate_cmd;
   logic       external_phase_pwm;
   logic       external_phase_pwm_oe_n;
   logic       power_good_out;
   logic       power_good_oe_n;
   logic       pg_line;
   logic       ext_phase_wire;
   int         mismatches = 0;
   int         n_compared = 0;
   int         cycles     = 0;

   rfp_top #(.OC_WAIT_TICKS(TICKS)) dut_u (.sys_clk, .arst_n, .addr, .wr_data, .wr_strobe,
      .rd_strobe, .rd_data_r, .irq_r, .regulator_enable, .soft_start_done, .soft_start_run_r,
      .uv_below_60, .out_above_70, .ov_trip, .avg_overcurrent_trip, .channel_current_limit,
      .pwm_req, .upper_gate_cmd, .lower_gate_cmd, .external_phase_pwm,
      .external_phase_pwm_oe_n, .power_good_out, .power_good_oe_n);
   rfp_stage_model stage_u (.sys_clk, .soft_start_run_r, .hold_ramp, .power_good_out,
      .power_good_oe_n, .external_phase_pwm, .external_phase_pwm_oe_n, .soft_start_done,
      .pg_line, .ext_phase_wire);

   task automatic complete_run;
      if (mismatches == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic bus_write(input rfp_addr_t a, input rfp_data_t d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge sys_clk);
      wr_strobe <= 1'b0;
   endtask

   task automatic rd_chk(input rfp_addr_t a, input rfp_data_t m, input rfp_data_t exp);
      @(posedge sys_clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge sys_clk);
      rd_strobe <= 1'b0;
      #1;
      check(rd_data_r & m, exp);
   endtask

   // Gates, external drive enable and resolved good line as one byte
   task automatic outs_are(input logic [7:0] e);
      check(32'({upper_gate_cmd, lower_gate_cmd, external_phase_pwm_oe_n, pg_line}), 32'(e));
   endtask

   task automatic start_up;
      @(posedge sys_clk);
      regulator_enable <= 1'b1;
      hold_ramp <= 1'b0;
      tick(2);
      for (int i = 0; i < 100 && soft_start_run_r === 1'b1; i++) tick(1);
      tick(1);
   endtask

   task automatic oc_wait_len(output int n, output logic off);
      n = 0;
      off = 1'b1;
      while (soft_start_run_r !== 1'b1 && n < 2000) begin
         off = off & ({upper_gate_cmd, lower_gate_cmd, external_phase_pwm_oe_n,
                       pg_line} === 8'h02);
         n++;
         tick(1);
      end
   endtask

   task automatic sc_reset;
      outs_are(8'h02);
      rd_chk(`RFP_ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
      rd_chk(`RFP_ADDR_MASK, 32'hFFFFFFFF, 32'h0);
      rd_chk(`RFP_ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      rd_chk(4'h2, 32'hFFFFFFFF, 32'h0);
      bus_write(`RFP_ADDR_STATE, 32'hFFFFFFFF);
      rd_chk(`RFP_ADDR_STATE, 32'hFFFFFFFF, 32'h0);
   endtask

   task automatic sc_startup;
      bus_write(`RFP_ADDR_CTRL, 32'h0);
      rd_chk(`RFP_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
      @(posedge sys_clk);
      regulator_enable <= 1'b1;
      tick(20);
      rd_chk(`RFP_ADDR_STATE, 32'hF, 32'h0);
      bus_write(`RFP_ADDR_CTRL, 32'h1);
      tick(20);
      check(32'({soft_start_run_r, pg_line}), 32'h2);
      rd_chk(`RFP_ADDR_STATE, 32'h7, 32'h1);
      start_up;
      outs_are(8'hA9);
      rd_chk(`RFP_ADDR_STATE, 32'h7, 32'h2);
   endtask

   task automatic sc_undervoltage;
      bus_write(`RFP_ADDR_MASK, 32'h1);
      @(posedge sys_clk);
      uv_below_60 <= 1'b1;
      tick(3);
      outs_are(8'hA8);
      check(32'(irq_r), 32'h1);
      rd_chk(`RFP_ADDR_STATE, 32'h7, 32'h2);
      @(posedge sys_clk);
      uv_below_60 <= 1'b0;
      tick(3);
      outs_are(8'hA8);
      @(posedge sys_clk);
      out_above_70 <= 1'b1;
      tick(3);
      outs_are(8'hA9);
      @(posedge sys_clk);
      out_above_70 <= 1'b0;
      bus_write(`RFP_ADDR_MASK, 32'h0);
      tick(2);
      check(32'(irq_r), 32'h0);
      rd_chk(`RFP_ADDR_STATUS, 32'h1, 32'h1);
      bus_write(`RFP_ADDR_STATUS, 32'h1);
      rd_chk(`RFP_ADDR_STATUS, 32'h1, 32'h0);
   endtask

   task automatic sc_channel_limit;
      @(posedge sys_clk);
      pwm_req <= 4'hF;
      channel_current_limit <= 4'h2;
      tick(1);
      outs_are(8'hA9);
      tick(5);
      outs_are(8'hA9);
      check(32'(ext_phase_wire), 32'h1);
      @(posedge sys_clk);
      channel_current_limit <= 4'h8;
      tick(1);
      outs_are(8'hE1);
      check(32'(ext_phase_wire), 32'h0);
      rd_chk(`RFP_ADDR_STATUS, 32'h8, 32'h8);
      @(posedge sys_clk);
      channel_current_limit <= 4'h0;
      pwm_req <= 4'h5;
      bus_write(`RFP_ADDR_STATUS, 32'h1F);
   endtask

   task automatic sc_overcurrent;
      int   n;
      logic off;
      @(posedge sys_clk);
      avg_overcurrent_trip <= 1'b1;
      channel_current_limit <= 4'h1;
      tick(1);
      outs_are(8'h02);
      oc_wait_len(n, off);
      check(32'(n), 32'(WAIT_CYC));
      check(32'(off), 32'h1);
      tick(1);
      outs_are(8'h02);
      @(posedge sys_clk);
      avg_overcurrent_trip <= 1'b0;
      channel_current_limit <= 4'h0;
      #1;
      oc_wait_len(n, off);
      check(32'(n + 1), 32'(WAIT_CYC));
      check(32'(soft_start_run_r), 32'h1);
      start_up;
      outs_are(8'hA9);
      rd_chk(`RFP_ADDR_STATUS, 32'h4, 32'h4);
      bus_write(`RFP_ADDR_STATUS, 32'h1F);
   endtask

   task automatic sc_open_sense;
      @(posedge sys_clk);
      ov_trip <= 1'b1;
      tick(1);
      outs_are(8'h1C);
      check(32'(ext_phase_wire), 32'h0);
      @(posedge sys_clk);
      ov_trip <= 1'b0;
      tick(2);
      outs_are(8'h02);
      tick(20);
      rd_chk(`RFP_ADDR_STATE, 32'h7, 32'h5);
      rd_chk(`RFP_ADDR_STATUS, 32'h12, 32'h12);
      @(posedge sys_clk);
      regulator_enable <= 1'b0;
      tick(2);
      rd_chk(`RFP_ADDR_STATE, 32'h7, 32'h0);
      start_up;
      rd_chk(`RFP_ADDR_STATE, 32'h7, 32'h2);
      outs_are(8'hA9);
   endtask

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Whole run needs about 1400 cycles; the ceiling leaves ample margin
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         mismatches++;
         complete_run;
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      sc_reset;
      sc_startup;
      sc_undervoltage;
      sc_channel_limit;
      sc_overcurrent;
      sc_open_sense;
      complete_run;
   end
endmodule // testbench
